// ---- common/cfm_pkg.sv ----
// package: clock fault monitor constants, tables and carrier types
package cfm_pkg;

  // monitored channels
  localparam int NUM_IN  = 4;
  localparam int NUM_PLL = 4;
  localparam int NUM_DEF = NUM_IN + NUM_PLL;
  localparam int DEF_W   = 3;
  // defect vector layout: inputs low, plls high
  localparam int LOSS_BASE   = 0;
  localparam int UNLOCK_BASE = NUM_IN;

  // core clock and the validation timer base tick
  localparam int CORE_CLK_HZ  = 20_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYC     = CORE_CLK_HZ / 1_000_000 * TICK_TIME_US;

  // validation wait times, counted in base ticks
  localparam int VAL_W = 10;
  localparam logic [VAL_W-1:0] VAL_TIME_2MS_MS   = 10'h002;
  localparam logic [VAL_W-1:0] VAL_TIME_100MS_MS = 10'h064;
  localparam logic [VAL_W-1:0] VAL_TIME_200MS_MS = 10'h0c8;
  localparam logic [VAL_W-1:0] VAL_TIME_1S_MS    = 10'h3e8;
  localparam logic [1:0] VAL_SEL_2MS   = 2'h0;
  localparam logic [1:0] VAL_SEL_100MS = 2'h1;
  localparam logic [1:0] VAL_SEL_200MS = 2'h2;
  localparam logic [1:0] VAL_SEL_1S    = 2'h3;

  // lock-loss ppm levels, in tenths of ppm
  localparam int PPM10_W = 16;
  localparam logic [PPM10_W-1:0] PPM10_0P2  = 16'h0002;
  localparam logic [PPM10_W-1:0] PPM10_0P4  = 16'h0004;
  localparam logic [PPM10_W-1:0] PPM10_2    = 16'h0014;
  localparam logic [PPM10_W-1:0] PPM10_4    = 16'h0028;
  localparam logic [PPM10_W-1:0] PPM10_20   = 16'h00c8;
  localparam logic [PPM10_W-1:0] PPM10_40   = 16'h0190;
  localparam logic [PPM10_W-1:0] PPM10_200  = 16'h07d0;
  localparam logic [PPM10_W-1:0] PPM10_400  = 16'h0fa0;
  localparam logic [PPM10_W-1:0] PPM10_2000 = 16'h4e20;
  localparam logic [PPM10_W-1:0] PPM10_4000 = 16'h9c40;
  localparam int PPM_SCALE  = 10_000_000;
  localparam int GATE_EDGES = 10_000_000;
  localparam int CNT_W      = 26;

  // config field widths
  localparam int PER_W     = 16;
  localparam int EDGE_W    = 8;
  localparam int SETTLE_W  = 8;
  localparam int SET_SEL_W = 4;
  localparam int CLR_SEL_W = 2;

  typedef struct packed {
    logic [PER_W-1:0]  exp_period;
    logic [EDGE_W-1:0] trig_edges;
    logic [EDGE_W-1:0] clear_edges;
    logic [1:0]        val_sel;
  } cfm_in_cfg_t;

  typedef struct packed {
    logic [SET_SEL_W-1:0] set_sel;
    logic [CLR_SEL_W-1:0] clr_sel;
    logic [SETTLE_W-1:0]  settle_win;
  } cfm_pll_cfg_t;

  typedef struct packed {
    logic               or_mode;
    logic [DEF_W-1:0]   sel;
    logic [NUM_DEF-1:0] mask;
  } cfm_flex_cfg_t;

  typedef enum logic [2:0] {
    CFM_ST_OK    = 3'h1,
    CFM_ST_LOST  = 3'h2,
    CFM_ST_VALID = 3'h4
  } cfm_loss_st_t;

endpackage

// ---- core/cfm_loss_mon.sv ----
// missing-edge clock loss monitor for one divided input clock
`timescale 1ns/100ps
`default_nettype none
module cfm_loss_mon (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 tick_i,
  input  wire logic                 edge_i,
  input  wire cfm_pkg::cfm_in_cfg_t cfg_i,
  output logic                      loss_o,
  output logic                      loss_rise_o
);
  import cfm_pkg::*;

  typedef struct packed {
    cfm_loss_st_t      st;
    logic [PER_W-1:0]  per_cnt;
    logic [EDGE_W-1:0] miss_run;
    logic [VAL_W-1:0]  val_cnt;
    logic              loss;
  } cfm_lm_state_t;

  // start lost: nothing is known about the clock until it validates
  localparam cfm_lm_state_t LM_RST = '{st: CFM_ST_LOST, loss: 1'b1, default: '0};

  cfm_lm_state_t     st_ff;
  cfm_lm_state_t     nxt_st;
  logic [PER_W:0]    per_inc;

  function automatic logic [VAL_W-1:0] val_limit(input logic [1:0] sel);
    case (sel)
      VAL_SEL_2MS:   val_limit = VAL_TIME_2MS_MS;
      VAL_SEL_100MS: val_limit = VAL_TIME_100MS_MS;
      VAL_SEL_200MS: val_limit = VAL_TIME_200MS_MS;
      default:       val_limit = VAL_TIME_1S_MS;
    endcase
  endfunction

  // next state: missing-edge run, then loss state machine
  always_comb begin
    nxt_st  = st_ff;
    per_inc = {1'b0, st_ff.per_cnt} + 1'b1;
    // one missing edge per expected period without an edge
    if (edge_i) begin
      nxt_st.per_cnt  = '0;
      nxt_st.miss_run = '0;
    end else if (per_inc >= {1'b0, cfg_i.exp_period}) begin
      nxt_st.per_cnt = '0;
      if (st_ff.miss_run != '1) begin
        nxt_st.miss_run = st_ff.miss_run + 1'b1;
      end
    end else begin
      nxt_st.per_cnt = per_inc[PER_W-1:0];
    end
    case (st_ff.st)
      CFM_ST_OK: begin
        if (nxt_st.miss_run >= cfg_i.trig_edges) begin
          nxt_st.st = CFM_ST_LOST;
        end
      end
      CFM_ST_LOST: begin
        // an edge means the clock is back; the run restarts from zero
        if (edge_i) begin
          nxt_st.st      = CFM_ST_VALID;
          nxt_st.val_cnt = '0;
        end
      end
      CFM_ST_VALID: begin
        if (nxt_st.miss_run >= cfg_i.clear_edges) begin
          nxt_st.st = CFM_ST_LOST;
        end else if (tick_i) begin
          if (st_ff.val_cnt + 1'b1 >= val_limit(cfg_i.val_sel)) begin
            nxt_st.st = CFM_ST_OK;
          end else begin
            nxt_st.val_cnt = st_ff.val_cnt + 1'b1;
          end
        end
      end
      default: begin
        nxt_st.st = CFM_ST_LOST;
      end
    endcase
    nxt_st.loss = (nxt_st.st != CFM_ST_OK);
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_ff <= LM_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // rise is early by design so the sticky bit lands with the live bit
  assign loss_o      = st_ff.loss;
  assign loss_rise_o = nxt_st.loss & ~st_ff.loss;

endmodule
`default_nettype wire

// ---- core/cfm_top.sv ----
// clock fault monitor: input loss, pll lock loss, sticky notify, alarm pins, irq
//
// Overview of operation
// - live status bit high only during defect
// - enabled sticky notify latches on first defect
// - notify holds until host clears it
// - alarm pin: one notify or OR set
// - masked notify bits drive interrupt pin
// - input monitors watch divided input clocks
// - four independent missing-edge loss monitors
// - loss when missing run reaches trigger
// - recovered when run stays below clear
// - loss drops after validation time passes
// - unlock when ref and fb frequencies differ
// - ten selectable set thresholds in ppm
// - four selectable clear thresholds, hysteresis
// - unlock drops after clean settling windows
// - unlock reported as status, notify, pins
// - status and notify visible to host
`timescale 1ns/100ps
`default_nettype none
module cfm_top #(
  parameter int TICK_CYC_P   = cfm_pkg::TICK_CYC,
  parameter int GATE_EDGES_P = cfm_pkg::GATE_EDGES,
  parameter int NUM_FLEX     = 4
) (
  input  wire logic                                          core_clk_i,
  input  wire logic                                          rst_i,
  input  wire logic [cfm_pkg::NUM_IN-1:0]                    clk_input_i,
  input  wire logic [cfm_pkg::NUM_PLL-1:0]                   pll_ref_clk_i,
  input  wire logic [cfm_pkg::NUM_PLL-1:0]                   pll_fb_clk_i,
  input  wire cfm_pkg::cfm_in_cfg_t [cfm_pkg::NUM_IN-1:0]    in_cfg_i,
  input  wire cfm_pkg::cfm_pll_cfg_t [cfm_pkg::NUM_PLL-1:0]  pll_cfg_i,
  input  wire cfm_pkg::cfm_flex_cfg_t [NUM_FLEX-1:0]         flex_cfg_i,
  input  wire logic [cfm_pkg::NUM_DEF-1:0]                   notify_en_i,
  input  wire logic [cfm_pkg::NUM_DEF-1:0]                   notify_clr_i,
  input  wire logic [cfm_pkg::NUM_DEF-1:0]                   irq_mask_i,
  output logic [cfm_pkg::NUM_IN-1:0]                         input_loss_flag_o,
  output logic [cfm_pkg::NUM_PLL-1:0]                        pll_unlock_flag_o,
  output logic [cfm_pkg::NUM_DEF-1:0]                        notify_o,
  output logic [NUM_FLEX-1:0]                                programmable_alarm_pin_o,
  output logic                                               irq_out_n_o
);
  import cfm_pkg::*;

  localparam int SYNC_W = NUM_IN + 2 * NUM_PLL;
  localparam int TICK_W = $clog2(TICK_CYC_P + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC_P - 1);
  localparam logic [CNT_W-1:0]  GATE_C    = CNT_W'(GATE_EDGES_P);
  localparam logic [CNT_W-1:0]  GATE_LAST = CNT_W'(GATE_EDGES_P - 1);

  // parameter sanity
  if (TICK_CYC_P < 1) begin : g_chk_tick
    $error("tick divider must be at least one cycle");
  end
  if (GATE_EDGES_P < 1 || GATE_EDGES_P >= 2 ** (CNT_W - 2)) begin : g_chk_gate
    $error("gate length does not fit the frequency counters");
  end
  if (NUM_FLEX < 1) begin : g_chk_flex
    $error("at least one alarm pin is needed");
  end

  typedef struct packed {
    logic [SYNC_W-1:0]                  sync1;
    logic [SYNC_W-1:0]                  sync2;
    logic [SYNC_W-1:0]                  sync3;
    logic [TICK_W-1:0]                  tick_cnt;
    logic                               tick;
    logic [NUM_PLL-1:0][CNT_W-1:0]      ref_cnt;
    logic [NUM_PLL-1:0][CNT_W-1:0]      fb_cnt;
    logic [NUM_PLL-1:0][SETTLE_W-1:0]   settle_cnt;
    logic [NUM_PLL-1:0]                 unlock;
    logic [NUM_DEF-1:0]                 notify;
    logic [NUM_FLEX-1:0]                flex;
    logic                               irq_n;
  } cfm_top_state_t;

  // irq pin is active low, so it idles high out of reset
  localparam cfm_top_state_t TOP_RST = '{irq_n: 1'b1, default: '0};

  cfm_top_state_t                 st_ff;
  cfm_top_state_t                 nxt_st;
  logic [SYNC_W-1:0]              rise;
  logic [NUM_IN-1:0]              in_edge;
  logic [NUM_PLL-1:0]             ref_edge;
  logic [NUM_PLL-1:0]             fb_edge;
  logic [NUM_IN-1:0]              loss;
  logic [NUM_IN-1:0]              loss_rise;
  logic [NUM_PLL-1:0]             unl_rise;
  logic [NUM_DEF-1:0]             def_rise;
  logic [NUM_PLL-1:0][CNT_W-1:0]  fb_tot;
  logic [NUM_PLL-1:0][CNT_W-1:0]  diff;

  // frequency error limit in fb edges per gate of ref edges
  function automatic logic [CNT_W-1:0] ppm_cnt(input logic [PPM10_W-1:0] ppm10);
    logic [63:0] prod;
    prod    = 64'(GATE_EDGES_P) * 64'(ppm10) / 64'(PPM_SCALE);
    ppm_cnt = prod[CNT_W-1:0];
  endfunction

  // set threshold decode; codes above nine take the widest level
  function automatic logic [CNT_W-1:0] set_thr(input logic [SET_SEL_W-1:0] sel);
    case (sel)
      4'h0:    set_thr = ppm_cnt(PPM10_0P2);
      4'h1:    set_thr = ppm_cnt(PPM10_0P4);
      4'h2:    set_thr = ppm_cnt(PPM10_2);
      4'h3:    set_thr = ppm_cnt(PPM10_4);
      4'h4:    set_thr = ppm_cnt(PPM10_20);
      4'h5:    set_thr = ppm_cnt(PPM10_40);
      4'h6:    set_thr = ppm_cnt(PPM10_200);
      4'h7:    set_thr = ppm_cnt(PPM10_400);
      4'h8:    set_thr = ppm_cnt(PPM10_2000);
      default: set_thr = ppm_cnt(PPM10_4000);
    endcase
  endfunction

  // clear threshold decode
  function automatic logic [CNT_W-1:0] clr_thr(input logic [CLR_SEL_W-1:0] sel);
    case (sel)
      2'h0:    clr_thr = ppm_cnt(PPM10_0P2);
      2'h1:    clr_thr = ppm_cnt(PPM10_0P4);
      2'h2:    clr_thr = ppm_cnt(PPM10_2);
      default: clr_thr = ppm_cnt(PPM10_200);
    endcase
  endfunction

  // rising edges are taken only from the second and third sync stages
  assign rise     = st_ff.sync2 & ~st_ff.sync3;
  assign in_edge  = rise[NUM_IN-1:0];
  assign ref_edge = rise[NUM_IN +: NUM_PLL];
  assign fb_edge  = rise[NUM_IN + NUM_PLL +: NUM_PLL];

  // one loss monitor per divided input clock
  for (genvar k = 0; k < NUM_IN; k++) begin : g_loss
    cfm_loss_mon u_loss (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .tick_i      (st_ff.tick),
      .edge_i      (in_edge[k]),
      .cfg_i       (in_cfg_i[k]),
      .loss_o      (loss[k]),
      .loss_rise_o (loss_rise[k])
    );
  end

  // next state
  always_comb begin
    nxt_st   = st_ff;
    fb_tot   = '0;
    diff     = '0;
    unl_rise = '0;
    def_rise = '0;

    // clocks are sampled at core rate, so each must stay below half of it
    nxt_st.sync1 = {pll_fb_clk_i, pll_ref_clk_i, clk_input_i};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;

    // base tick for the validation timers
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt == TICK_LAST) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
    end

    // per pll: count fb edges over a gate of ref edges, then judge
    for (int p = 0; p < NUM_PLL; p++) begin
      // fb counter saturates so a runaway fb clock still reads as a large error
      if (fb_edge[p] && st_ff.fb_cnt[p] != '1) begin
        fb_tot[p] = st_ff.fb_cnt[p] + 1'b1;
      end else begin
        fb_tot[p] = st_ff.fb_cnt[p];
      end
      if (fb_tot[p] > GATE_C) begin
        diff[p] = fb_tot[p] - GATE_C;
      end else begin
        diff[p] = GATE_C - fb_tot[p];
      end
      nxt_st.fb_cnt[p] = fb_tot[p];
      if (ref_edge[p]) begin
        if (st_ff.ref_cnt[p] == GATE_LAST) begin
          nxt_st.ref_cnt[p] = '0;
          nxt_st.fb_cnt[p]  = '0;
          if (diff[p] > set_thr(pll_cfg_i[p].set_sel)) begin
            nxt_st.unlock[p]     = 1'b1;
            nxt_st.settle_cnt[p] = '0;
          end else if (st_ff.unlock[p]) begin
            if (diff[p] > clr_thr(pll_cfg_i[p].clr_sel)) begin
              // still outside the clear band: settling starts over
              nxt_st.settle_cnt[p] = '0;
            end else if (st_ff.settle_cnt[p] + 1'b1 >= pll_cfg_i[p].settle_win) begin
              nxt_st.unlock[p]     = 1'b0;
              nxt_st.settle_cnt[p] = '0;
            end else begin
              nxt_st.settle_cnt[p] = st_ff.settle_cnt[p] + 1'b1;
            end
          end
        end else begin
          nxt_st.ref_cnt[p] = st_ff.ref_cnt[p] + 1'b1;
        end
      end
      unl_rise[p] = nxt_st.unlock[p] & ~st_ff.unlock[p];
    end

    // sticky notify: a new set outranks a clear in the same cycle
    def_rise[LOSS_BASE +: NUM_IN]     = loss_rise;
    def_rise[UNLOCK_BASE +: NUM_PLL]  = unl_rise;
    nxt_st.notify = (st_ff.notify & ~notify_clr_i)
                  | (notify_en_i & def_rise);

    // alarm pins follow the new notify value with no extra lag
    for (int f = 0; f < NUM_FLEX; f++) begin
      if (flex_cfg_i[f].or_mode) begin
        nxt_st.flex[f] = |(nxt_st.notify & flex_cfg_i[f].mask);
      end else begin
        nxt_st.flex[f] = nxt_st.notify[flex_cfg_i[f].sel];
      end
    end

    // interrupt is the masked OR of notify, driven low when active
    nxt_st.irq_n = ~|(nxt_st.notify & irq_mask_i);
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_ff <= TOP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign input_loss_flag_o        = loss;
  assign pll_unlock_flag_o        = st_ff.unlock;
  assign notify_o                 = st_ff.notify;
  assign programmable_alarm_pin_o = st_ff.flex;
  assign irq_out_n_o              = st_ff.irq_n;

endmodule
`default_nettype wire

// ---- tb/cfm_top_props.sv ----
// checker: port-level assertions for the clock fault monitor
`timescale 1ns/100ps
`default_nettype none
module cfm_top_props #(
  parameter int TICK_CYC_P   = 10,
  parameter int GATE_EDGES_P = 1000,
  parameter int NUM_FLEX     = 4
) (
  input wire logic                                         core_clk_i,
  input wire logic                                         rst_i,
  input wire logic [cfm_pkg::NUM_IN-1:0]                   clk_input_i,
  input wire logic [cfm_pkg::NUM_PLL-1:0]                  pll_ref_clk_i,
  input wire logic [cfm_pkg::NUM_PLL-1:0]                  pll_fb_clk_i,
  input wire cfm_pkg::cfm_in_cfg_t [cfm_pkg::NUM_IN-1:0]   in_cfg_i,
  input wire cfm_pkg::cfm_pll_cfg_t [cfm_pkg::NUM_PLL-1:0] pll_cfg_i,
  input wire cfm_pkg::cfm_flex_cfg_t [NUM_FLEX-1:0]        flex_cfg_i,
  input wire logic [cfm_pkg::NUM_DEF-1:0]                  notify_en_i,
  input wire logic [cfm_pkg::NUM_DEF-1:0]                  notify_clr_i,
  input wire logic [cfm_pkg::NUM_DEF-1:0]                  irq_mask_i,
  input wire logic [cfm_pkg::NUM_IN-1:0]                   input_loss_flag_o,
  input wire logic [cfm_pkg::NUM_PLL-1:0]                  pll_unlock_flag_o,
  input wire logic [cfm_pkg::NUM_DEF-1:0]                  notify_o,
  input wire logic [NUM_FLEX-1:0]                          programmable_alarm_pin_o,
  input wire logic                                         irq_out_n_o
);
  import cfm_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [NUM_DEF-1:0]            flag_all;
  logic [NUM_FLEX-1:0]           alarm_exp;
  cfm_flex_cfg_t [NUM_FLEX-1:0]  flex_ff;
  logic [NUM_IN-1:0]             in_ff;
  int                            quiet_ff [NUM_IN];
  assign flag_all = {pll_unlock_flag_o, input_loss_flag_o};
  // raw pin quiet time; the design sees edges later, so this only overestimates
  always_ff @(posedge core_clk_i) begin
    flex_ff <= flex_cfg_i;
    in_ff <= clk_input_i;
    for (int k = 0; k < NUM_IN; k++) begin
      if (clk_input_i[k] && !in_ff[k]) quiet_ff[k] <= 0;
      else if (quiet_ff[k] < 1_000_000) quiet_ff[k] <= quiet_ff[k] + 1;
    end
  end
  // pin value expected from the config in force when notify updated
  always_comb begin
    for (int k = 0; k < NUM_FLEX; k++) begin
      alarm_exp[k] = flex_ff[k].or_mode ? |(notify_o & flex_ff[k].mask)
                                        : notify_o[flex_ff[k].sel];
    end
  end
  AST_NOTIFY_SET: assert property (
    (~$past(flag_all) & flag_all & $past(notify_en_i) & ~notify_o) == '0)
    else $error("notify missed a new defect");
  AST_NOTIFY_CAUSE: assert property (
    (~$past(notify_o) & notify_o & ~(flag_all & ~$past(flag_all))) == '0)
    else $error("notify set without a rising defect");
  AST_NOTIFY_HOLD: assert property (
    ($past(notify_o) & ~$past(notify_clr_i) & ~notify_o) == '0)
    else $error("notify dropped without a clear");
  AST_NOTIFY_CLR: assert property (
    (notify_o & $past(notify_clr_i) & ~(flag_all & ~$past(flag_all))) == '0)
    else $error("notify survived a clear");
  AST_IRQ: assert property (irq_out_n_o == !(|(notify_o & $past(irq_mask_i))))
    else $error("interrupt pin disagrees with masked notify");
  AST_ALARM: assert property (programmable_alarm_pin_o == alarm_exp)
    else $error("alarm pin disagrees with its selection");
  for (genvar k = 0; k < NUM_IN; k++) begin : g_in
    AST_LOSS_HOLD: assert property (
      $rose(input_loss_flag_o[k]) |-> input_loss_flag_o[k] [*8])
      else $error("loss flag dropped too soon");
    AST_LOSS_EARLY: assert property (
      $rose(input_loss_flag_o[k])
      |-> quiet_ff[k] >= in_cfg_i[k].trig_edges * in_cfg_i[k].exp_period)
      else $error("loss declared while edges present");
    AST_LOSS_LATE: assert property (
      quiet_ff[k] == in_cfg_i[k].trig_edges * in_cfg_i[k].exp_period + 8
      |-> input_loss_flag_o[k])
      else $error("loss not declared after missing edges");
  end
endmodule
bind cfm_top cfm_top_props #(
  .TICK_CYC_P(TICK_CYC_P), .GATE_EDGES_P(GATE_EDGES_P), .NUM_FLEX(NUM_FLEX)
) i_props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_input_i(clk_input_i),
  .pll_ref_clk_i(pll_ref_clk_i), .pll_fb_clk_i(pll_fb_clk_i), .in_cfg_i(in_cfg_i),
  .pll_cfg_i(pll_cfg_i), .flex_cfg_i(flex_cfg_i),
  .notify_en_i(notify_en_i), .notify_clr_i(notify_clr_i), .irq_mask_i(irq_mask_i),
  .input_loss_flag_o(input_loss_flag_o), .pll_unlock_flag_o(pll_unlock_flag_o),
  .notify_o(notify_o), .programmable_alarm_pin_o(programmable_alarm_pin_o),
  .irq_out_n_o(irq_out_n_o));
`default_nettype wire

// ---- tb/cfm_clk_src.sv ----
// clock source model: divided input clocks, pll reference and feedback clocks
`timescale 1ns/100ps
`default_nettype none
module cfm_clk_src (
  input  wire logic [3:0] in_run_i,
  input  wire logic [3:0] fb_run_i,
  output logic      [3:0] in_clk_o,
  output logic      [3:0] ref_o,
  output logic      [3:0] fb_o
);
  logic ph_in  = 1'b0;
  logic ph_ref = 1'b0;
  // post-predivider clocks, phase unrelated to the core clock
  always #100.3 ph_in = ~ph_in;
  always #150.7 ph_ref = ~ph_ref;
  // a stopped clock stands low; feedback equals reference when running
  assign in_clk_o = {4{ph_in}} & in_run_i;
  assign ref_o    = {4{ph_ref}};
  assign fb_o     = {4{ph_ref}} & fb_run_i;
endmodule
`default_nettype wire

// ---- tb/cfm_top_test.sv ----
// testbench: clock fault monitor against the clock source model
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("CHECK FAILED at %0t: %s", $time, msg); \
  end \
end
module cfm_top_test;
  import cfm_pkg::*;
  localparam int TICK = 10;
  localparam int GATE = 1000;
  localparam int VALT [4] = '{2, 100, 200, 1000};
  logic                       core_clk_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic [3:0]                 in_run = 4'hf;
  logic [3:0]                 fb_run = 4'hf;
  logic [3:0]                 clk_in, ref_clk, fb_clk, loss, unlock, alarm;
  logic [7:0]                 n_en = 8'hfb;
  logic [7:0]                 n_clr = 8'h00;
  logic [7:0]                 irq_mask = 8'h41;
  logic [7:0]                 notify, flags;
  logic                       irq_n;
  cfm_in_cfg_t  [3:0]         in_cfg;
  cfm_pll_cfg_t [3:0]         pll_cfg;
  cfm_flex_cfg_t [3:0]        flex_cfg;
  int                         n_fail = 0;
  int                         total_checks = 0;
  int                         n;
  assign flags = {unlock, loss};
  always #25 core_clk_i = ~core_clk_i;
  cfm_clk_src i_src (.in_run_i(in_run), .fb_run_i(fb_run), .in_clk_o(clk_in), .ref_o(ref_clk),
    .fb_o(fb_clk));
  cfm_top #(.TICK_CYC_P(TICK), .GATE_EDGES_P(GATE), .NUM_FLEX(4)) i_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_input_i(clk_in), .pll_ref_clk_i(ref_clk),
    .pll_fb_clk_i(fb_clk), .in_cfg_i(in_cfg), .pll_cfg_i(pll_cfg), .flex_cfg_i(flex_cfg),
    .notify_en_i(n_en), .notify_clr_i(n_clr), .irq_mask_i(irq_mask),
    .input_loss_flag_o(loss), .pll_unlock_flag_o(unlock), .notify_o(notify),
    .programmable_alarm_pin_o(alarm), .irq_out_n_o(irq_n));
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
    #2;
  endtask
  // bounded wait on one defect flag, settled after the edge
  task automatic wait_bit(input int idx, input logic val, input int lim, output int cnt);
    cnt = 0;
    while (flags[idx] !== val && cnt < lim) begin
      cyc(1);
      cnt++;
    end
    `CHK(flags[idx], val, "flag did not reach expected level")
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard, about twice the expected run
  initial begin
    #4ms;
    n_fail++;
    wrap_up();
  end
  initial begin
    for (int k = 0; k < 4; k++) begin
      in_cfg[k] = '{exp_period: 16'h0008, trig_edges: 8'h03, clear_edges: 8'h02,
                    val_sel: k[1:0]};
      pll_cfg[k] = '{set_sel: 4'(k * 3), clr_sel: k[1:0], settle_win: 8'h02};
    end
    flex_cfg[0] = '{or_mode: 1'b0, sel: 3'h1, mask: 8'h00};
    flex_cfg[1] = '{or_mode: 1'b1, sel: 3'h0, mask: 8'h48};
    flex_cfg[2] = '{or_mode: 1'b0, sel: 3'h6, mask: 8'h00};
    flex_cfg[3] = '{or_mode: 1'b1, sel: 3'h0, mask: 8'h00};
    cyc(16);
    rst_i = 1'b0;
    `CHK(loss, 4'hf, "loss flags after reset")
    `CHK({notify, unlock, alarm, irq_n}, 17'h00001, "outputs after reset")
    wait_bit(3, 1'b0, 10200, n);
    `CHK(flags, 8'h00, "defects after start")
    $display("test reset done");
    // each input in turn, each validation time once
    for (int i = 0; i < 4; i++) begin
      in_run[i] = 1'b0;
      wait_bit(i, 1'b1, 60, n);
      `CHK(n >= 18, 1'b1, "loss declared early")
      `CHK(notify[i], (i != 2), "notify versus enable")
      `CHK(loss & ~(4'h1 << i), 4'h0, "other inputs disturbed")
      in_run[i] = 1'b1;
      wait_bit(i, 1'b0, VALT[i] * TICK + 40, n);
      `CHK(n >= (VALT[i] - 1) * TICK, 1'b1, "loss cleared before validation")
    end
    `CHK({notify, alarm, irq_n}, {8'h0b, 4'h3, 1'b0}, "sticky state after recovery")
    n_clr = 8'h09;
    cyc(1);
    n_clr = 8'h00;
    cyc(1);
    `CHK({notify, alarm, irq_n}, {8'h02, 4'h1, 1'b1}, "state after partial clear")
    $display("test input loss done");
    // feedback of pll 2 stops, then returns
    fb_run[2] = 1'b0;
    wait_bit(6, 1'b1, 14 * GATE, n);
    `CHK({unlock, notify, alarm, irq_n}, {4'h4, 8'h42, 4'h7, 1'b0}, "unlock reporting")
    fb_run[2] = 1'b1;
    wait_bit(6, 1'b0, 21 * GATE, n);
    `CHK(n >= 11900, 1'b1, "unlock cleared before settling")
    `CHK(notify, 8'h42, "notify kept after unlock ends")
    $display("test lock loss done");
    // a set on the same edge as a held clear must win
    n_clr = 8'hff;
    in_run[0] = 1'b0;
    wait_bit(0, 1'b1, 60, n);
    `CHK(notify, 8'h01, "new set lost against clear")
    cyc(1);
    `CHK({notify, irq_n}, 9'h001, "held clear removes notify")
    n_clr = 8'h00;
    // long validation so the clock can die again while still validating
    in_cfg[0].val_sel = VAL_SEL_100MS;
    in_run[0] = 1'b1;
    $display("test set against clear done");
    // edges return, then stop inside validation: loss must hold, no new rise
    cyc(6);
    in_run[0] = 1'b0;
    cyc(1100);
    `CHK({loss[0], notify[0]}, 2'b10, "clear-edge run did not hold loss")
    $display("test aborted recovery done");
    wrap_up();
  end
endmodule
`default_nettype wire
